/* File: hdl/cph_host.sv */
// host end of the byte handshake: sends or receives 32-bit words as four bytes
`timescale 1ns/100ps
module cph_host #(
	parameter bit START_TX = 1'b1
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [31:0] tx_data,
	output logic rx_valid,
	input wire logic rx_ready,
	output logic [31:0] rx_data,
	output logic link_tx,
	input wire logic byte_strobe_n_in,
	output logic byte_strobe_n_out,
	output logic byte_strobe_n_oe,
	input wire logic byte_ready_n_in,
	output logic byte_ready_n_out,
	output logic byte_ready_n_oe,
	input wire logic [7:0] port_data_lines_in,
	output logic [7:0] port_data_lines_out,
	output logic port_data_lines_oe
);
	typedef enum logic [2:0] {
		ST_IDLE, ST_TX_STROBE, ST_TX_WAIT_HI, ST_RX_WAIT_LO, ST_RX_WAIT_HI, ST_RX_PUSH
	} cph_state_t;
	cph_state_t state_ff, nxt_state;
	// three stage input sync; a change counts when stages two and three agree
	logic [2:0] stb_sync_ff, rdy_sync_ff;
	logic stb_ff, rdy_ff;
	logic [7:0] d_s1_ff, d_s2_ff;
	logic [1:0] idx_ff, nxt_idx;
	logic [31:0] word_ff, nxt_word;
	logic [7:0] dout_ff, nxt_dout;
	logic stb_out_ff, nxt_stb_out;
	logic rdy_out_ff, nxt_rdy_out;
	logic tx_mode_ff;
	logic rxf_valid;
	logic rxf_ready;
	logic txf_valid;
	logic [31:0] txf_data;
	// pop only on the cycle the idle state really loads the word
	wire tx_take = (state_ff == ST_IDLE) && tx_mode_ff && txf_valid && rdy_ff;
	always_ff @(posedge clk) begin
		if (reset) begin
			stb_sync_ff <= 3'h7;
			rdy_sync_ff <= 3'h7;
			stb_ff <= 1'b1;
			rdy_ff <= 1'b1;
		end else begin
			stb_sync_ff <= {stb_sync_ff[1:0], byte_strobe_n_in};
			rdy_sync_ff <= {rdy_sync_ff[1:0], byte_ready_n_in};
			if (stb_sync_ff[1] == stb_sync_ff[2])
				stb_ff <= stb_sync_ff[2];
			if (rdy_sync_ff[1] == rdy_sync_ff[2])
				rdy_ff <= rdy_sync_ff[2];
		end
	end
	// data is captured two stages deep, fewer than the three sync stages plus filter register on the strobe path
	always_ff @(posedge clk) begin
		d_s1_ff <= port_data_lines_in;
		d_s2_ff <= d_s1_ff;
	end
	// outgoing words are buffered; a full buffer stalls the user via tx_ready
	cph_fifo #(.WIDTH(cph_pkg::WORD_W), .DEPTH(cph_pkg::FIFO_DEPTH)) u_txf (
		.clk(clk),
		.reset(reset),
		.in_valid(tx_valid),
		.in_ready(tx_ready),
		.in_data(tx_data),
		.out_valid(txf_valid),
		.out_ready(tx_take),
		.out_data(txf_data)
	);
	always_comb begin
		nxt_state = state_ff;
		nxt_idx = idx_ff;
		nxt_word = word_ff;
		nxt_dout = dout_ff;
		nxt_stb_out = stb_out_ff;
		nxt_rdy_out = rdy_out_ff;
		rxf_valid = 1'b0;
		unique case (state_ff)
			ST_IDLE: begin
				if (tx_mode_ff) begin
					if (txf_valid && rdy_ff) begin
						nxt_word = txf_data;
						nxt_dout = txf_data[7:0];
						nxt_idx = 2'h0;
						nxt_state = ST_TX_STROBE;
					end
				end else begin
					nxt_idx = 2'h0;
					nxt_state = ST_RX_WAIT_LO;
				end
			end
			ST_TX_STROBE: begin
				// data was set up a cycle earlier, now strobe falls
				nxt_stb_out = 1'b0;
				if (!stb_out_ff && !rdy_ff) begin
					nxt_stb_out = 1'b1;
					if (idx_ff != cph_pkg::LAST_BYTE)
						nxt_dout = word_ff[8*(idx_ff+2'h1) +: 8];
					nxt_state = ST_TX_WAIT_HI;
				end
			end
			ST_TX_WAIT_HI: begin
				if (rdy_ff) begin
					if (idx_ff == cph_pkg::LAST_BYTE)
						nxt_state = ST_IDLE;
					else begin
						nxt_idx = idx_ff + 2'h1;
						nxt_state = ST_TX_STROBE;
					end
				end
			end
			ST_RX_WAIT_LO: begin
				// wait for room before acknowledging, stalling the device
				if (!stb_ff && rxf_ready) begin
					nxt_word[8*idx_ff +: 8] = d_s2_ff;
					nxt_rdy_out = 1'b0;
					nxt_state = ST_RX_WAIT_HI;
				end
			end
			ST_RX_WAIT_HI: begin
				if (stb_ff) begin
					nxt_rdy_out = 1'b1;
					if (idx_ff == cph_pkg::LAST_BYTE)
						nxt_state = ST_RX_PUSH;
					else begin
						nxt_idx = idx_ff + 2'h1;
						nxt_state = ST_RX_WAIT_LO;
					end
				end
			end
			ST_RX_PUSH: begin
				rxf_valid = 1'b1;
				nxt_idx = 2'h0;
				nxt_state = ST_RX_WAIT_LO;
			end
			default: nxt_state = ST_IDLE;
		endcase
	end
	cph_fifo #(.WIDTH(cph_pkg::WORD_W), .DEPTH(cph_pkg::FIFO_DEPTH)) u_rxf (
		.clk(clk),
		.reset(reset),
		.in_valid(rxf_valid),
		.in_ready(rxf_ready),
		.in_data(word_ff),
		.out_valid(rx_valid),
		.out_ready(rx_ready),
		.out_data(rx_data)
	);
	always_ff @(posedge clk) begin
		if (reset) begin
			state_ff <= ST_IDLE;
			idx_ff <= 2'h0;
			word_ff <= 32'h0;
			dout_ff <= 8'h0;
			stb_out_ff <= 1'b1;
			rdy_out_ff <= 1'b1;
			tx_mode_ff <= START_TX;
		end else begin
			state_ff <= nxt_state;
			idx_ff <= nxt_idx;
			word_ff <= nxt_word;
			dout_ff <= nxt_dout;
			stb_out_ff <= nxt_stb_out;
			rdy_out_ff <= nxt_rdy_out;
		end
	end
	assign link_tx = tx_mode_ff;
	assign byte_strobe_n_out = stb_out_ff;
	// direction is fixed; pins the host does not own stay released
	assign byte_strobe_n_oe = tx_mode_ff;
	assign byte_ready_n_out = rdy_out_ff;
	assign byte_ready_n_oe = !tx_mode_ff;
	assign port_data_lines_out = dout_ff;
	assign port_data_lines_oe = tx_mode_ff;
endmodule // cph_host

/* File: hdl/cph_pkg.sv */
// package of constants and types for the comm port byte handshake host
// Notes on behaviour
// - when sending, byte 0 is on the data lines before strobe falls
// - after ready falls the sender drives the next byte and raises strobe
// - sender waits for ready high before strobing again, bytes 1 to 3
// - after byte 3 the sender may keep it on the data lines
// - on old devices strobe rises within one clock after ready falls; the host raises it about five clocks later, behind the input sync and filter
// - next word strobe may fall any time after ready rises
// - when receiving, read the byte after strobe falls, then pull ready low
// - then wait for strobe high and drive ready high again
// - token request and acknowledge handshake with released pins; the host has no token logic, its direction is fixed by START_TX
// - an unused port keeps its control inputs high
// - a lost byte is not recovered; only a global reset helps
package cph_pkg;
	localparam int WORD_W = 32;
	localparam int BYTE_W = 8;
	localparam int BYTES_PER_WORD = 4;
	localparam int FIFO_DEPTH = 32;
	localparam logic [1:0] LAST_BYTE = 2'h3;
	typedef struct packed {
		logic strobe_n;
		logic ready_n;
		logic req_n;
		logic ack_n;
	} cph_ctl_t;
endpackage

/* File: hdl/cph_fifo.sv */
// synchronous word fifo with valid and ready on both sides
`timescale 1ns/100ps
module cph_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	// only power-of-two depths wrap the pointers correctly
	if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_params
		$error("cph_fifo needs a width of at least one and a power-of-two depth");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ff, rd_ff;
	logic in_ready_ff, out_valid_ff;
	logic [WIDTH-1:0] out_data_ff;
	wire push = in_valid && in_ready_ff;
	wire pop = out_valid_ff && out_ready;
	wire [AW:0] nxt_wr = wr_ff + (AW+1)'(push);
	wire [AW:0] nxt_rd = rd_ff + (AW+1)'(pop);
	wire [AW:0] nxt_fill = nxt_wr - nxt_rd;
	// a word written into the slot about to be read is passed straight through
	wire fwd = push && (wr_ff[AW-1:0] == nxt_rd[AW-1:0]);
	assign in_ready = in_ready_ff;
	assign out_valid = out_valid_ff;
	assign out_data = out_data_ff;
	always_ff @(posedge clk) begin
		if (push)
			mem[wr_ff[AW-1:0]] <= in_data;
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			wr_ff <= '0;
			rd_ff <= '0;
			in_ready_ff <= 1'b1;
			out_valid_ff <= 1'b0;
			out_data_ff <= '0;
		end else begin
			wr_ff <= nxt_wr;
			rd_ff <= nxt_rd;
			in_ready_ff <= nxt_fill != (AW+1)'(DEPTH);
			out_valid_ff <= nxt_fill != '0;
			out_data_ff <= fwd ? in_data : mem[nxt_rd[AW-1:0]];
		end
	end
endmodule // cph_fifo

/* File: dv/cph_host_asserts.sv */
// assertions on the host port pins
`timescale 1ns/100ps
module cph_host_asserts (
	input wire logic clk,
	input wire logic reset,
	input wire logic link_tx,
	input wire logic byte_strobe_n_in,
	input wire logic byte_strobe_n_out,
	input wire logic byte_ready_n_in,
	input wire logic byte_ready_n_out,
	input wire logic [7:0] port_data_lines_out,
	input wire logic rx_valid
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_ack;
		link_tx ##0 $fell(byte_ready_n_in);
	endsequence
	a_strobe_holds: assert property (link_tx && !byte_strobe_n_out && byte_ready_n_in |=>
		!byte_strobe_n_out) else $error("strobe dropped");
	a_data_stable: assert property (link_tx && !byte_strobe_n_out |->
		$stable(port_data_lines_out)) else $error("data moved");
	a_strobe_rise: assert property (s_ack |-> ##[1:6] byte_strobe_n_out)
		else $error("strobe stuck");
	a_no_restrobe: assert property (link_tx && !byte_ready_n_in && byte_strobe_n_out |=>
		byte_strobe_n_out) else $error("early strobe");
	a_rx_ack: assert property (!link_tx && $fell(byte_strobe_n_in) |->
		##[1:8] !byte_ready_n_out) else $error("no ack");
	a_rx_release: assert property (!link_tx && $rose(byte_strobe_n_in) |->
		##[1:8] byte_ready_n_out) else $error("no release");
	a_rx_wait: assert property (!link_tx && !byte_ready_n_out && !byte_strobe_n_in |=>
		!byte_ready_n_out) else $error("early release");
	a_reset_idle: assert property ($fell(reset) |->
		byte_strobe_n_out && byte_ready_n_out && !rx_valid) else $error("bad idle");
endmodule // cph_host_asserts
bind cph_host cph_host_asserts cph_host_asserts_i (.clk, .reset, .link_tx, .byte_strobe_n_in,
	.byte_strobe_n_out, .byte_ready_n_in, .byte_ready_n_out, .port_data_lines_out, .rx_valid);

/* File: dv/cph_dev.sv */
// port model: receives words on one port, sends them back on the other
`timescale 1ns/100ps
module cph_dev (
	input wire logic clk,
	input wire logic stall,
	input wire logic in_stb_n,
	input wire logic [7:0] in_data,
	output logic in_rdy_n,
	output logic out_stb_n,
	output logic [7:0] out_data,
	input wire logic out_rdy_n
);
	logic [31:0] w;
	initial begin
		in_rdy_n = 1'b1;
		out_stb_n = 1'b1;
		out_data = 8'hFF;
		forever begin
			for (int k = 0; k < 4; k++) begin
				do @(posedge clk); while (in_stb_n);
				w[8*k+:8] = in_data;
				while (stall) @(posedge clk);
				in_rdy_n <= 1'b0;
				do @(posedge clk); while (!in_stb_n);
				in_rdy_n <= 1'b1;
			end
			for (int k = 0; k < 4; k++) begin
				// next byte only once ready is back high
				do @(posedge clk); while (!out_rdy_n);
				out_data <= w[8*k+:8];
				@(posedge clk);
				out_stb_n <= 1'b0;
				do @(posedge clk); while (out_rdy_n);
				out_stb_n <= 1'b1;
				out_data <= ~w[8*k+:8];
			end
		end
	end
endmodule // cph_dev

/* File: dv/cph_host_test.sv */
// testbench: words go out of one host, through the port model, into the other
`timescale 1ns/100ps
module cph_host_test;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic tx_valid = 1'b0;
	logic stall = 1'b0;
	logic rx_rdy = 1'b1;
	logic a_roe, b_soe, b_doe;
	logic [31:0] tx_data = 32'h0;
	logic tx_ready, a_ltx, b_ltx, a_so, a_soe, a_doe, b_ro, b_roe, d_rdy, d_stb, b_val, a_sd, b_rw;
	logic [7:0] a_do, a_dat, d_dat;
	logic [31:0] b_rxd;
	logic [31:0] q[$];
	int bad_count = 0;
	int cmp_count = 0;
	always #5 clk = ~clk;
	assign a_sd = a_soe ? a_so : 1'b1;
	assign a_dat = a_doe ? a_do : 8'hFF;
	assign b_rw = b_roe ? b_ro : 1'b1;
	always @(posedge clk) if (b_val && rx_rdy) q.push_back(b_rxd);
	cph_host #(.START_TX(1'b1)) cph_host_tx_i (.clk, .reset, .tx_valid, .tx_ready, .tx_data,
		.rx_valid(), .rx_ready(1'b0), .rx_data(), .link_tx(a_ltx), .byte_strobe_n_in(a_sd),
		.byte_strobe_n_out(a_so), .byte_strobe_n_oe(a_soe), .byte_ready_n_in(d_rdy),
		.byte_ready_n_out(), .byte_ready_n_oe(a_roe), .port_data_lines_in(a_dat),
		.port_data_lines_out(a_do), .port_data_lines_oe(a_doe));
	cph_host #(.START_TX(1'b0)) cph_host_rx_i (.clk, .reset, .tx_valid(1'b0), .tx_ready(),
		.tx_data(32'h0), .rx_valid(b_val), .rx_ready(rx_rdy), .rx_data(b_rxd), .link_tx(b_ltx),
		.byte_strobe_n_in(d_stb), .byte_strobe_n_out(), .byte_strobe_n_oe(b_soe),
		.byte_ready_n_in(b_rw), .byte_ready_n_out(b_ro), .byte_ready_n_oe(b_roe),
		.port_data_lines_in(d_dat), .port_data_lines_out(), .port_data_lines_oe(b_doe));
	cph_dev cph_dev_i (.clk, .stall, .in_stb_n(a_sd), .in_data(a_dat), .in_rdy_n(d_rdy),
		.out_stb_n(d_stb), .out_data(d_dat), .out_rdy_n(b_rw));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic put(input logic [31:0] w);
		int i;
		@(posedge clk);
		tx_valid <= 1'b1;
		tx_data <= w;
		for (i = 0; i < 9000; i++) begin
			@(negedge clk);
			if (tx_ready) break;
		end
		if (i == 9000) begin
			bad_count++;
			print_verdict;
		end else begin
			@(posedge clk);
			tx_valid <= 1'b0;
		end
	endtask
	task automatic expect_words(input int n, input logic [31:0] base, input int step);
		int i;
		for (i = 0; i < 30000 && q.size() < n; i++) @(posedge clk);
		if (i == 30000) begin
			bad_count++;
			print_verdict;
		end else begin
			for (i = 0; i < n; i++) chk(q.pop_front(), base + i * step);
		end
	endtask
	task automatic t_order;
		int i;
		chk({a_ltx, b_ltx, a_so, b_ro}, 32'hB);
		chk({a_roe, b_soe, b_doe}, 32'h0);
		put(32'h44332211);
		for (i = 0; i < 50 && a_sd; i++) @(negedge clk);
		chk({a_sd, a_dat}, 32'h11);
		expect_words(1, 32'h44332211, 0);
	endtask
	task automatic t_back;
		put(32'h0);
		put(32'h7FFFFFFF);
		put(32'hFFFFFFFE);
		expect_words(3, 32'h0, 32'h7FFFFFFF);
	endtask
	task automatic t_hold;
		int i;
		rx_rdy <= 1'b0;
		put(32'hC3C30F0F);
		for (i = 0; i < 2000 && !b_val; i++) @(posedge clk);
		repeat (4) @(posedge clk);
		chk({31'h0, b_val}, 32'h1);
		chk(b_rxd, 32'hC3C30F0F);
		rx_rdy <= 1'b1;
		expect_words(1, 32'hC3C30F0F, 0);
	endtask
	task automatic t_reset;
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		chk({a_ltx, b_ltx, a_so, b_ro}, 32'hB);
		put(32'h5A5AA5A5);
		expect_words(1, 32'h5A5AA5A5, 0);
	endtask
	task automatic t_fill;
		int n;
		n = 0;
		stall <= 1'b1;
		@(posedge clk);
		tx_valid <= 1'b1;
		while (n < 40) begin
			tx_data <= 32'hA0000000 + n;
			@(negedge clk);
			if (!tx_ready) break;
			@(posedge clk);
			n++;
		end
		@(posedge clk);
		tx_valid <= 1'b0;
		stall <= 1'b0;
		chk({31'h0, n >= 32 && n <= 34}, 32'h1);
		expect_words(n, 32'hA0000000, 1);
	endtask
	initial begin
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		t_order;
		t_back;
		t_hold;
		t_fill;
		t_reset;
		print_verdict;
	end
endmodule // cph_host_test
